//--- rtl/fast_data_port_defines.vh
`ifndef FAST_DATA_PORT_DEFINES_VH
`define FAST_DATA_PORT_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map (word index; the byte address is four times it)
// ----------------------------------------------------------------------------
`define REG_CONTROL        4'h0
`define REG_DRIVE_TIMING   4'h1
`define REG_TIMING_A       4'h2
`define REG_TIMING_B       4'h3
`define REG_STATUS         4'h4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_ENABLE_BIT     0
`define CTL_START_BIT      1
`define TIM_RD_LSB         0
`define TIM_WR_LSB         4
`define TIM_REC_LSB        8
`define TIM_SU_LSB         12
`define DRV_ISA_LSB        8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CONTROL_RESET      32'h0000_0000
`define DRIVE_RESET        32'h0000_00FE
`define TIMING_RESET       32'h0000_3F60

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define REC_COUNT_MAX      5'h18
`define SU_COUNT_MAX       3'h4
`define T2_FIRST_WAIT      2'h1
`define T2_SECOND_WAIT     2'h2

`endif

//--- rtl/drive_decode.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Drive decode: picks the drive from the data port and the select bit
// ----------------------------------------------------------------------------
module drive_decode (
  input  wire [1:0] port_sel,
  input  wire [3:0] odd_bits,
  input  wire [7:0] set_b_map,
  input  wire [3:0] isa_map,
  output wire [2:0] drive_num,
  output wire       use_set_b,
  output wire       use_isa
);

  // Even drive on bit 4 low, odd on high
  assign drive_num = {port_sel, odd_bits[port_sel]};
  assign use_set_b = set_b_map[drive_num];
  // Only drives 0-3 may be sent to the ISA path
  assign use_isa   = (drive_num[2] == 1'b0) ? isa_map[drive_num[1:0]] : 1'b0;

endmodule // drive_decode

//--- rtl/fast_data_port.v
// How it works
// - Never sample IOCS16; data port is 16-bit
// - Drives 0-3 may take ISA path
// - Check ready one clock before end; stretch
// - Ready goes through two-flop synchroniser
// - Defaults only when no ISA, grant high
// - Default: address lines 0, cs0 0, cs1 1
// - Global earliest start: first or second T2
// - Read/write widths 1-16 clocks per set
// - Recovery 1-8, then 10-24 by twos
// - Two sets; each drive picks one
// - Drive from data port and select bit
// - Counter tracks default hold; setup checked
// - Recovery counter resets on command, counts idle
// - Recovery delays data-port accesses only
// - Recovery also between split 32-bit halves
// - Engine runs on local bus clock
// - ISA-routed drives honour acknowledge in ISA logic
// - 32-bit access becomes two 16-bit cycles
// - Strobes from engine only for data port
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "fast_data_port_defines.vh"

module fast_data_port (
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Local-bus data-port request
  input  wire        dp_req,
  input  wire        dp_write,
  input  wire        dp_dword,
  input  wire [1:0]  dp_port,
  input  wire [3:0]  dp_odd_bits,
  input  wire        t2_end,
  output wire        dp_done,
  output wire        dp_isa_route,
  // System side
  input  wire        isa_cycle_active,
  input  wire        master_grant_n,
  input  wire        isa_read_n,
  input  wire        isa_write_n,
  input  wire        isa_addr_bit0,
  input  wire        isa_addr_bit1,
  input  wire        isa_addr_bit2,
  input  wire        isa_cmd_sel_n,
  input  wire        isa_ctl_sel_n,
  input  wire        iochrdy,
  // Drive pins
  output reg         drive_read_strobe_n,
  output reg         drive_write_strobe_n,
  output reg         drive_addr_bit0,
  output reg         drive_addr_bit1,
  output reg         drive_addr_bit2,
  output reg         drive_cmd_block_sel_n,
  output reg         drive_ctl_block_sel_n,
  output reg         dp_half
);

  // --------------------------------------------------------------------------
  // State codes
  // --------------------------------------------------------------------------
  localparam [4:0] ST_IDLE  = 5'b00001; // Waiting for an access
  localparam [4:0] ST_WAIT  = 5'b00010; // T2 count, setup and recovery
  localparam [4:0] ST_CMD   = 5'b00100; // Strobe low
  localparam [4:0] ST_HOLD  = 5'b01000; // Stretched by ready
  localparam [4:0] ST_DONE  = 5'b10000; // Answer pulse

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [31:0] control;     // Enable, start choice
  reg  [31:0] drive_map;   // Set B map, ISA map
  reg  [31:0] timing_a;    // Set A widths
  reg  [31:0] timing_b;    // Set B widths
  reg  [4:0]  state;       // Engine state
  reg  [4:0]  cmd_cnt;     // Remaining command clocks
  reg  [4:0]  rec_cnt;     // Idle clocks since last command
  reg  [2:0]  su_cnt;      // Clocks defaults held
  reg  [1:0]  t2_cnt;      // T2 ends seen
  reg         ready_meta;  // Synchroniser stage one
  reg         ready_sync;  // Synchroniser stage two
  reg         ap_valid;    // Bus data phase pending
  reg         ap_write;    // Pending is write
  reg  [3:0]  ap_addr;     // Pending word index
  reg         second;      // Second half of a dword
  reg         dir_write;   // Latched direction
  reg         sel_b;       // Latched timing set
  wire [2:0]  drive_num;
  wire        use_set_b;
  wire        use_isa;

  // --------------------------------------------------------------------------
  // Drive decode
  // --------------------------------------------------------------------------
  drive_decode u_decode (
    .port_sel  (dp_port),
    .odd_bits  (dp_odd_bits),
    .set_b_map (drive_map[7:0]),
    .isa_map   (drive_map[11:8]),
    .drive_num (drive_num),
    .use_set_b (use_set_b),
    .use_isa   (use_isa)
  );

  // ISA-routed accesses leave the engine; acknowledge handled there
  assign dp_isa_route = dp_req & (use_isa | ~control[`CTL_ENABLE_BIT]);

  // --------------------------------------------------------------------------
  // Timing decode functions
  // --------------------------------------------------------------------------
  // Pulse width: code 0 means 16
  function [4:0] width_of;
    input [3:0] code;
    begin
      width_of = (code == 4'h0) ? 5'h10 : {1'b0, code};
    end
  endfunction

  // Recovery: 1-8 direct, 9-F give 10-22, 0 gives 24
  function [4:0] rec_of;
    input [3:0] code;
    begin
      if (code == 4'h0) begin
        rec_of = `REC_COUNT_MAX;
      end else if (code <= 4'h8) begin
        rec_of = {1'b0, code};
      end else begin
        rec_of = {code, 1'b0} - 5'h08;
      end
    end
  endfunction

  // Setup: code 0 means 4
  function [2:0] setup_of;
    input [1:0] code;
    begin
      setup_of = (code == 2'h0) ? `SU_COUNT_MAX : {1'b0, code};
    end
  endfunction

  wire [31:0] tim     = sel_b ? timing_b : timing_a;
  wire [4:0]  rd_w    = width_of(tim[`TIM_RD_LSB+3:`TIM_RD_LSB]);
  wire [4:0]  wr_w    = width_of(tim[`TIM_WR_LSB+3:`TIM_WR_LSB]);
  wire [4:0]  rec_w   = rec_of(tim[`TIM_REC_LSB+3:`TIM_REC_LSB]);
  wire [2:0]  su_w    = setup_of(tim[`TIM_SU_LSB+1:`TIM_SU_LSB]);
  wire [1:0]  t2_need = control[`CTL_START_BIT] ? `T2_SECOND_WAIT : `T2_FIRST_WAIT;
  // Defaults allowed only with no ISA cycle and grant high
  wire defaults_ok = ~isa_cycle_active & master_grant_n;
  wire cmd_active  = (state == ST_CMD) | (state == ST_HOLD);
  wire start_ok    = (t2_cnt >= t2_need) | second;
  wire setup_ok    = (su_cnt >= su_w);
  wire rec_ok      = (rec_cnt >= rec_w);

  // --------------------------------------------------------------------------
  // Ready synchroniser, local-bus clock
  // --------------------------------------------------------------------------
  // Two flops keep a metastable ready out of the engine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_meta <= 1'b1;
      ready_sync <= 1'b1;
    end else begin
      ready_meta <= iochrdy;
      ready_sync <= ready_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Setup and recovery counters
  // --------------------------------------------------------------------------
  // Setup counter counts up to 4 while defaults stand, then holds
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      su_cnt  <= 3'h0;
      rec_cnt <= `REC_COUNT_MAX;
    end else begin
      if (!defaults_ok) begin
        su_cnt <= 3'h0;
      end else if (su_cnt != `SU_COUNT_MAX) begin
        su_cnt <= su_cnt + 3'h1;
      end
      // Any drive command, ISA or fast, restarts recovery
      if (cmd_active | ~isa_read_n | ~isa_write_n) begin
        rec_cnt <= 5'h0;
      end else if (rec_cnt != `REC_COUNT_MAX) begin
        rec_cnt <= rec_cnt + 5'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Engine state machine, clocked by the local bus
  // --------------------------------------------------------------------------
  // Width counts down; ready is checked with one clock left
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      cmd_cnt   <= 5'h0;
      t2_cnt    <= 2'h0;
      second    <= 1'b0;
      dir_write <= 1'b0;
      sel_b     <= 1'b0;
      dp_half   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          t2_cnt <= 2'h0;
          second <= 1'b0;
          // Only data-port accesses enter; others stay with ISA logic
          if (dp_req && !dp_isa_route) begin
            dir_write <= dp_write;
            sel_b     <= use_set_b;
            dp_half   <= 1'b0;
            state     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (t2_end && t2_cnt != 2'h3) begin
            t2_cnt <= t2_cnt + 2'h1;
          end
          // Recovery is only checked here, on the data-port path
          if (start_ok && setup_ok && rec_ok) begin
            cmd_cnt <= dir_write ? wr_w : rd_w;
            state   <= ST_CMD;
          end
        end
        ST_CMD: begin
          // One clock before the end, look at synced ready
          if (cmd_cnt == 5'h1) begin
            if (!ready_sync) begin
              state <= ST_HOLD;
            end else if (dp_dword && !second) begin
              second  <= 1'b1;
              dp_half <= 1'b1;
              state   <= ST_WAIT;
            end else begin
              state <= ST_DONE;
            end
          end else begin
            cmd_cnt <= cmd_cnt - 5'h1;
          end
        end
        ST_HOLD: begin
          // Release one clock after ready seen high
          if (ready_sync) begin
            if (dp_dword && !second) begin
              second  <= 1'b1;
              dp_half <= 1'b1;
              state   <= ST_WAIT;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign dp_done = (state == ST_DONE);
  // --------------------------------------------------------------------------
  // Drive pins
  // --------------------------------------------------------------------------
  // Strobes: OR of ISA commands and engine; width taken as 16 bits always
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_read_strobe_n   <= 1'b1;
      drive_write_strobe_n  <= 1'b1;
      drive_addr_bit0       <= 1'b0;
      drive_addr_bit1       <= 1'b0;
      drive_addr_bit2       <= 1'b0;
      drive_cmd_block_sel_n <= 1'b0;
      drive_ctl_block_sel_n <= 1'b1;
    end else begin
      drive_read_strobe_n  <= isa_read_n &
                              ~(state == ST_WAIT && start_ok && setup_ok && rec_ok && !dir_write
                                || cmd_active && !dir_write && !(state == ST_CMD && cmd_cnt == 5'h1
                                && ready_sync) && !(state == ST_HOLD && ready_sync));
      drive_write_strobe_n <= isa_write_n &
                              ~(state == ST_WAIT && start_ok && setup_ok && rec_ok && dir_write
                                || cmd_active && dir_write && !(state == ST_CMD && cmd_cnt == 5'h1
                                && ready_sync) && !(state == ST_HOLD && ready_sync));
      if (defaults_ok) begin
        drive_addr_bit0       <= 1'b0;
        drive_addr_bit1       <= 1'b0;
        drive_addr_bit2       <= 1'b0;
        drive_cmd_block_sel_n <= 1'b0;
        drive_ctl_block_sel_n <= 1'b1;
      end else begin
        drive_addr_bit0       <= isa_addr_bit0;
        drive_addr_bit1       <= isa_addr_bit1;
        drive_addr_bit2       <= isa_addr_bit2;
        drive_cmd_block_sel_n <= isa_cmd_sel_n;
        drive_ctl_block_sel_n <= isa_ctl_sel_n;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  // Zero wait states; response always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Latch the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 4'h0;
    end else if (hready) begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[5:2];
    end
  end

  // Register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control   <= `CONTROL_RESET;
      drive_map <= `DRIVE_RESET;
      timing_a  <= `TIMING_RESET;
      timing_b  <= `TIMING_RESET;
    end else if (ap_valid && ap_write) begin
      case (ap_addr)
        `REG_CONTROL:      control   <= {30'h0, hwdata[1:0]};
        `REG_DRIVE_TIMING: drive_map <= {20'h0, hwdata[11:0]};
        `REG_TIMING_A:     timing_a  <= {18'h0, hwdata[13:0]};
        `REG_TIMING_B:     timing_b  <= {18'h0, hwdata[13:0]};
        default: ;
      endcase
    end
  end

  // Read data registered at the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[5:2])
        `REG_CONTROL:      hrdata <= control;
        `REG_DRIVE_TIMING: hrdata <= drive_map;
        `REG_TIMING_A:     hrdata <= timing_a;
        `REG_TIMING_B:     hrdata <= timing_b;
        `REG_STATUS:       hrdata <= {11'h0, rec_cnt, 5'h0, su_cnt, 2'h0, ready_sync, state};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // fast_data_port

//--- bench/fast_data_port_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the data-port engine
// ----------------------------------------
module fast_data_port_monitor (
  input wire hclk,
  input wire hresetn,
  input wire dp_req,
  input wire dp_done,
  input wire dp_isa_route,
  input wire dp_half,
  input wire isa_cycle_active,
  input wire master_grant_n,
  input wire isa_read_n,
  input wire isa_write_n,
  input wire isa_ctl_sel_n,
  input wire iochrdy,
  input wire drive_read_strobe_n,
  input wire drive_write_strobe_n,
  input wire drive_addr_bit0,
  input wire drive_addr_bit1,
  input wire drive_addr_bit2,
  input wire drive_cmd_block_sel_n,
  input wire drive_ctl_block_sel_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire       idle = drive_read_strobe_n && drive_write_strobe_n;  // No strobe low
  wire       owns = !isa_cycle_active && master_grant_n;          // CPU side owns pins
  wire [4:0] pins = {drive_ctl_block_sel_n, drive_cmd_block_sel_n,
                     drive_addr_bit2, drive_addr_bit1, drive_addr_bit0};
  logic [5:0] lo_cnt;  // Clocks the read strobe has been low
  // Past 16 clocks only a not-ready drive or an ISA read can still hold the strobe
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lo_cnt <= 6'h00;
    else if (drive_read_strobe_n) lo_cnt <= 6'h00;
    else if (lo_cnt != 6'h3F) lo_cnt <= lo_cnt + 6'h01;
  end
  sequence s_stall; (!drive_read_strobe_n && !iochrdy) [*4]; endsequence
  sequence s_long; !drive_read_strobe_n && lo_cnt > 6'h10 && $rose(iochrdy); endsequence
  sequence s_isa; (isa_cycle_active && $stable(isa_ctl_sel_n)) [*2]; endsequence

  a_one_strobe: assert property (!drive_read_strobe_n |-> drive_write_strobe_n)
    else $error("both strobes low");
  a_default_pins: assert property (owns && $past(owns) |-> pins == 5'h10)
    else $error("pins off default");
  a_ready_hold: assert property (s_stall |=> !drive_read_strobe_n)
    else $error("strobe ended while not ready");
  a_ready_free: assert property (s_long |-> ##[1:5] drive_read_strobe_n)
    else $error("strobe held after ready");
  a_isa_follow: assert property (s_isa |-> drive_ctl_block_sel_n == isa_ctl_sel_n)
    else $error("select not from isa side");
  a_route_quiet: assert property ((dp_req && dp_isa_route && isa_read_n
    && isa_write_n) [*2] |-> idle)
    else $error("engine strobed a routed drive");
  a_done_idle: assert property (dp_done |-> idle)
    else $error("done during strobe");
  a_half_gap: assert property ($rose(dp_half) |-> idle || $past(idle))
    else $error("half flag moved mid strobe");
endmodule // fast_data_port_monitor

bind fast_data_port fast_data_port_monitor mon (
  .hclk, .hresetn, .dp_req, .dp_done, .dp_isa_route, .dp_half, .isa_cycle_active,
  .master_grant_n, .isa_read_n, .isa_write_n, .isa_ctl_sel_n, .iochrdy,
  .drive_read_strobe_n, .drive_write_strobe_n, .drive_addr_bit0, .drive_addr_bit1,
  .drive_addr_bit2, .drive_cmd_block_sel_n, .drive_ctl_block_sel_n
);

//--- bench/drive_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Drive: times strobes, can stall ready
// ----------------------------------------
module drive_model (
  input  wire       hclk,
  input  wire       read_n,
  input  wire       write_n,
  input  wire [4:0] stall,
  output wire       iochrdy
);
  int   width = 0;   // Low clocks of the last pulse
  int   gap = 0;     // High clocks before the last pulse
  int   pulses = 0;  // Pulses seen
  int   lo = 0;
  int   hi = 0;
  int   hold = 0;    // Not-ready clocks still owed
  wire  cmd = !(read_n && write_n);
  logic was = 1'b0;
  logic seen = 1'b0;   // Command seen at the last edge
  logic armed = 1'b0;  // Stall still owed after the last edge
  // Ready has a pull-up: high between commands, low at once for a stalled one
  assign iochrdy = !(cmd && (seen ? armed : stall != 5'h00));
  always @(posedge hclk) begin
    if (cmd && !was) begin
      gap = hi;
      pulses++;
      lo = 0;
      hold = stall;
    end
    if (!cmd && was) begin
      width = lo;
      hi = 0;
    end
    if (cmd) lo++;
    else hi++;
    if (hold != 0) hold--;
    was = cmd;
    seen <= cmd;
    armed <= (hold != 0);
  end
endmodule // drive_model

//--- bench/test_fast_data_port.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the data-port engine
// ----------------------------------------
module test_fast_data_port;
  logic        hclk, hresetn, hsel, hwrite, dp_req, dp_write, dp_dword, t2_end;
  logic        isa_cycle_active, master_grant_n, isa_read_n, isa_write_n;
  logic        isa_cmd_sel_n, isa_ctl_sel_n, isa_addr_bit0, isa_addr_bit1, isa_addr_bit2;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans, dp_port;
  logic [2:0]  hsize;
  logic [3:0]  dp_odd_bits;
  logic [4:0]  stall;
  wire         hready, hreadyout, hresp, dp_done, dp_isa_route, dp_half, iochrdy;
  wire         drive_read_strobe_n, drive_write_strobe_n, drive_addr_bit0;
  wire         drive_addr_bit1, drive_addr_bit2, drive_cmd_block_sel_n, drive_ctl_block_sel_n;
  wire  [31:0] hrdata;
  wire  [4:0]  pins = {drive_ctl_block_sel_n, drive_cmd_block_sel_n,
                       drive_addr_bit2, drive_addr_bit1, drive_addr_bit0};
  int          n_errors = 0, n_checks = 0, cycles = 0, t2_seen = 0;
  logic        started = 1'b0;  // First strobe of this request seen
  assign hready = hreadyout;  // Only slave on the bus

  fast_data_port dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .dp_req, .dp_write, .dp_dword, .dp_port,
    .dp_odd_bits, .t2_end, .dp_done, .dp_isa_route, .isa_cycle_active, .master_grant_n,
    .isa_read_n, .isa_write_n, .isa_addr_bit0, .isa_addr_bit1, .isa_addr_bit2,
    .isa_cmd_sel_n, .isa_ctl_sel_n, .iochrdy, .drive_read_strobe_n, .drive_write_strobe_n,
    .drive_addr_bit0, .drive_addr_bit1, .drive_addr_bit2, .drive_cmd_block_sel_n,
    .drive_ctl_block_sel_n, .dp_half);
  drive_model drv (.hclk, .read_n(drive_read_strobe_n), .write_n(drive_write_strobe_n),
    .stall, .iochrdy);

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // T2 ends every other clock while a request waits
  always @(posedge hclk) t2_end <= dp_req && !t2_end;
  // T2 ends seen before the first strobe of the current request
  always @(posedge hclk) begin
    if (!dp_req) begin
      t2_seen <= 0;
      started <= 1'b0;
    end else if (!(drive_read_strobe_n && drive_write_strobe_n)) begin
      started <= 1'b1;
    end else if (t2_end && !started) begin
      t2_seen <= t2_seen + 1;
    end
  end
  // Hang guard, far above the few hundred clocks the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic chk_ge(input string nm, input int lo, input int got);
    n_checks++;
    if (got < lo) begin
      n_errors++;
      $display("unexpected %s expected at least %0d seen %0d", nm, lo, got);
    end
  endtask
  // One single word transfer; waits on ready, never on a cycle count
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(nm, exp, q);
  endtask
  // One engine request, held until the done pulse
  task automatic dp_go(input logic [1:0] p, input logic odd, input logic w, input logic dw);
    int i;
    @(posedge hclk);
    dp_port <= p;
    dp_odd_bits <= {4{odd}};
    dp_write <= w;
    dp_dword <= dw;
    dp_req <= 1'b1;
    for (i = 0; i < 400; i++) begin
      @(posedge hclk);
      if (dp_done === 1'b1) break;
    end
    dp_req <= 1'b0;
    chk("done", 1, dp_done);
    @(posedge hclk);  // Let the drive model log the pulse
  endtask

  task t_reset;
    rd_chk("control", 8'h00, 32'h0000_0000);
    rd_chk("drive map", 8'h04, 32'h0000_00FE);
    rd_chk("timing a", 8'h08, 32'h0000_3F60);
    rd_chk("timing b", 8'h0C, 32'h0000_3F60);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
    chk("pins", 32'h0000_0010, {27'h0, pins});
    chk("resp okay", 0, hresp);
  endtask
  // Odd drives on set B; every port and select bit reaches its drive
  task t_drives;
    int d;
    wr(8'h08, 16'h1C23);  // A: setup 1, recovery 16, write 2, read 3
    wr(8'h0C, 16'h2315);  // B: setup 2, recovery 3, write 1, read 5
    wr(8'h04, 16'h00AA);
    wr(8'h00, 16'h0001);
    for (d = 0; d < 8; d++) begin
      dp_go(d[2:1], d[0], 1'b0, 1'b0);
      chk("read width", d[0] ? 5 : 3, drv.width);
      if (d == 0) chk("early start", 1, t2_seen);
    end
    dp_go(2'h0, 1'b0, 1'b1, 1'b0);
    chk("write width a", 2, drv.width);
    dp_go(2'h2, 1'b1, 1'b1, 1'b0);
    chk("write width b", 1, drv.width);
  endtask
  // Recovery between requests and between the halves of a dword
  task t_recovery;
    int p;
    dp_go(2'h0, 1'b0, 1'b0, 1'b0);
    dp_go(2'h0, 1'b0, 1'b0, 1'b0);
    chk_ge("gap back to back", 16, drv.gap);
    p = drv.pulses;
    dp_go(2'h0, 1'b0, 1'b1, 1'b1);
    chk("dword halves", p + 2, drv.pulses);
    chk_ge("dword gap", 16, drv.gap);
    stall <= 5'h14;
    dp_go(2'h0, 1'b0, 1'b0, 1'b0);
    chk_ge("stretched width", 20, drv.width);
    stall <= 5'h00;
  endtask
  // Drives 0-3 may go to the ISA path, 4-7 stay on the engine
  task t_route;
    int p;
    wr(8'h04, 16'h0FAA);
    @(posedge hclk);
    dp_port <= 2'h1;
    dp_odd_bits <= 4'hF;
    dp_req <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("route drive 3", 1, dp_isa_route);
    dp_req <= 1'b0;
    p = drv.pulses;
    dp_go(2'h3, 1'b1, 1'b0, 1'b0);
    chk("drive 7 served", p + 1, drv.pulses);
    wr(8'h04, 16'h00AA);
    wr(8'h00, 16'h0003);
    repeat (20) @(posedge hclk);  // Recovery met, so only the start bit delays
    dp_go(2'h0, 1'b0, 1'b0, 1'b0);
    chk("late start width", 3, drv.width);
    chk("late start", 2, t2_seen);
  endtask
  // An ISA cycle or a foreign master takes the pins off their defaults
  task t_isa_pins;
    int k;
    for (k = 0; k < 2; k++) begin
      @(posedge hclk);
      {isa_cycle_active, master_grant_n} <= (k == 0) ? 2'h3 : 2'h0;
      {isa_ctl_sel_n, isa_cmd_sel_n} <= 2'h1;
      {isa_addr_bit2, isa_addr_bit1, isa_addr_bit0} <= 3'h7;
      repeat (3) @(posedge hclk);
      chk("isa pins", 32'h0000_000F, {27'h0, pins});
      {isa_cycle_active, master_grant_n} <= 2'h1;
      {isa_ctl_sel_n, isa_cmd_sel_n} <= 2'h2;
      repeat (3) @(posedge hclk);
      chk("pins restored", 32'h0000_0010, {27'h0, pins});
    end
  endtask

  task tally_and_finish;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    {hresetn, hwrite, dp_req, dp_write, dp_dword, t2_end, isa_cycle_active} = '0;
    {isa_addr_bit0, isa_addr_bit1, isa_addr_bit2, isa_cmd_sel_n} = '0;
    {hsel, master_grant_n, isa_read_n, isa_write_n, isa_ctl_sel_n} = '1;
    {haddr, hwdata, htrans, dp_port, dp_odd_bits, stall} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_drives;
    t_recovery;
    t_route;
    t_isa_pins;
    tally_and_finish;
  end
endmodule // test_fast_data_port
